/* hdl/gear_coupler.sv */
// electronic gearing axis coupler: one slave axis follows a chosen leader
`timescale 1ns/1ps
// Operation
// - two modes: standard gear and dual-drive gantry
// - leader, ramp rate, ratio set at 60h-62h
// - start command addressed to the slave axis
// - slave moves with leader scaled by ratio
// - standard: ratio ramps up at ramp rate
// - standard: ratio changes live, rate limited
// - standard: release, stop, estop, servo-off release
// - standard: slave alarm inputs spare the leader
// - gantry: only manual release ends coupling
// - gantry: slave alarm inputs stop the leader
// - gantry: stop commands halt both axes
// - gantry: ratio fixed at one, rate ignored
// - gantry: check error every motion cycle
// - gantry: limit one starts decelerating stop
// - gantry: limit two switches both drives off
// - gantry limits held at 63h and 64h
// - bit 28 set while axis follows
module gear_coupler (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic cycle_tick_i,
    input wire logic signed [31:0] leader_step_i [gear_pkg::AXES],
    input wire logic signed [31:0] leader_pos_i [gear_pkg::AXES],
    input wire logic signed [31:0] slave_pos_i,
    input wire gear_pkg::axis_in_s slave_in_i,
    output logic signed [31:0] slave_step_o,
    output logic slave_step_valid_o,
    output gear_pkg::drive_cmd_s drive_cmd_o,
    output logic irq_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        gear_pkg::couple_e mode;
        logic [gear_pkg::AXIS_W-1:0] leader;
        logic [31:0] rate;
        logic [31:0] ratio;
        logic [31:0] limit_one;
        logic [31:0] limit_two;
        logic [31:0] eff_ratio;
        logic gantry_sel;
        logic [31:0] rdata;
        logic signed [31:0] step;
        logic step_valid;
        gear_pkg::drive_cmd_s cmd;
        logic [gear_pkg::EV_W-1:0] ev;
        logic [gear_pkg::EV_W-1:0] mask;
        logic irq;
        logic [3:0] in_s1;
        logic [3:0] in_s2;
        logic [3:0] in_s3;
        logic in_act;
        logic lim1_hit;
        logic lim2_hit;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // ratio moves toward target by at most rate per motion cycle
    function automatic logic [31:0] ramp(input logic [31:0] cur, input logic [31:0] tgt,
                                         input logic [31:0] rate);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (cur < tgt) begin
            d = tgt - cur;
            ramp = (d > rate) ? cur + rate : tgt;
        end else begin
            d = cur - tgt;
            ramp = (d > rate) ? cur - rate : tgt;
        end
    endfunction

    // scaled step: leader step times Q16.16 ratio
    function automatic logic signed [31:0] scale(input logic signed [31:0] s,
                                                 input logic [31:0] r);
        logic signed [63:0] p;
        p = s * $signed({1'b0, r});
        scale = p[gear_pkg::FRAC +: 32];
    endfunction

    logic signed [31:0] lead_step;
    logic signed [31:0] lead_pos;
    logic signed [31:0] pos_diff;
    logic [31:0] pos_err;
    logic in_now;
    logic [gear_pkg::EV_W-1:0] ev_set;

    assign lead_step = leader_step_i[st_ff.leader];
    assign lead_pos = leader_pos_i[st_ff.leader];
    assign pos_diff = lead_pos - slave_pos_i;
    assign pos_err = pos_diff[31] ? 32'(-pos_diff) : 32'(pos_diff);
    // inputs count active once second and third stage agree
    assign in_now = (st_ff.in_s2 == st_ff.in_s3) && (|st_ff.in_s3);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        ev_set = '0;
        nxt_st.cmd = '0;
        nxt_st.step_valid = 1'b0;
        nxt_st.rdata = 32'h0000_0000;
        nxt_st.in_s1 = slave_in_i;
        nxt_st.in_s2 = st_ff.in_s1;
        nxt_st.in_s3 = st_ff.in_s2;
        if (st_ff.in_s2 == st_ff.in_s3) begin
            nxt_st.in_act = |st_ff.in_s3;
        end
        // register writes, settings bound to this slave axis
        if (wr_i) begin
            unique case (addr_i)
                gear_pkg::PRM_LEADER_SEL: nxt_st.leader = wdata_i[gear_pkg::AXIS_W-1:0];
                gear_pkg::PRM_RAMP_RATE: nxt_st.rate = wdata_i;
                gear_pkg::PRM_FOLLOW_RATIO: nxt_st.ratio = wdata_i;
                gear_pkg::PRM_LIMIT_ONE: nxt_st.limit_one = wdata_i;
                gear_pkg::PRM_LIMIT_TWO: nxt_st.limit_two = wdata_i;
                gear_pkg::REG_IRQ_MASK: nxt_st.mask = wdata_i[gear_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        // control commands
        if (wr_i && addr_i == gear_pkg::REG_CONTROL) begin
            if (wdata_i[gear_pkg::CTL_GANTRY]) begin
                nxt_st.gantry_sel = 1'b1;
            end else begin
                nxt_st.gantry_sel = 1'b0;
            end
            if (st_ff.mode == gear_pkg::ST_IDLE && wdata_i[gear_pkg::CTL_START]) begin
                nxt_st.mode = wdata_i[gear_pkg::CTL_GANTRY] ? gear_pkg::ST_GANTRY
                                                             : gear_pkg::ST_STANDARD;
                nxt_st.eff_ratio = wdata_i[gear_pkg::CTL_GANTRY] ? gear_pkg::RATIO_UNITY
                                                                  : 32'h0000_0000;
                nxt_st.lim1_hit = 1'b0;
                nxt_st.lim2_hit = 1'b0;
                ev_set[gear_pkg::EV_ENGAGED] = 1'b1;
            end else if (st_ff.mode != gear_pkg::ST_IDLE) begin
                if (wdata_i[gear_pkg::CTL_RELEASE]) begin
                    nxt_st.mode = gear_pkg::ST_IDLE;
                    ev_set[gear_pkg::EV_RELEASED] = 1'b1;
                end else if (wdata_i[gear_pkg::CTL_STOP] | wdata_i[gear_pkg::CTL_ESTOP]
                             | wdata_i[gear_pkg::CTL_SERVO_OFF]) begin
                    if (st_ff.mode == gear_pkg::ST_STANDARD) begin
                        nxt_st.mode = gear_pkg::ST_IDLE;
                        ev_set[gear_pkg::EV_RELEASED] = 1'b1;
                    end else begin
                        // gantry stays coupled, both axes halt
                        nxt_st.cmd.leader_stop = 1'b1;
                        nxt_st.cmd.slave_stop = 1'b1;
                        nxt_st.cmd.servo_off = wdata_i[gear_pkg::CTL_SERVO_OFF];
                    end
                end
            end
        end
        // per motion cycle following and protection
        if (cycle_tick_i && st_ff.mode != gear_pkg::ST_IDLE) begin
            if (st_ff.mode == gear_pkg::ST_STANDARD) begin
                nxt_st.eff_ratio = ramp(st_ff.eff_ratio, st_ff.ratio, st_ff.rate);
                nxt_st.step = scale(lead_step, st_ff.eff_ratio);
            end else begin
                nxt_st.step = lead_step;
                if (pos_err > st_ff.limit_two && !st_ff.lim2_hit) begin
                    nxt_st.cmd.servo_off = 1'b1;
                    nxt_st.cmd.leader_stop = 1'b1;
                    nxt_st.cmd.slave_stop = 1'b1;
                    nxt_st.lim2_hit = 1'b1;
                    ev_set[gear_pkg::EV_LIMIT_TWO] = 1'b1;
                end else if (pos_err > st_ff.limit_one && !st_ff.lim1_hit) begin
                    nxt_st.cmd.leader_stop = 1'b1;
                    nxt_st.cmd.slave_stop = 1'b1;
                    nxt_st.lim1_hit = 1'b1;
                    ev_set[gear_pkg::EV_LIMIT_ONE] = 1'b1;
                end
            end
            nxt_st.step_valid = 1'b1;
        end
        // slave alarm inputs: leader only stopped in gantry
        if (in_now && !st_ff.in_act && st_ff.mode == gear_pkg::ST_GANTRY) begin
            nxt_st.cmd.leader_stop = 1'b1;
            ev_set[gear_pkg::EV_INPUT_TRIP] = 1'b1;
        end
        // sticky events, set wins over write-one-clear
        if (wr_i && addr_i == gear_pkg::REG_IRQ_STAT) begin
            nxt_st.ev = st_ff.ev & ~wdata_i[gear_pkg::EV_W-1:0];
        end
        nxt_st.ev = nxt_st.ev | ev_set;
        nxt_st.irq = |(nxt_st.ev & nxt_st.mask);
        // read data one cycle after the strobe
        if (rd_i) begin
            unique case (addr_i)
                gear_pkg::PRM_LEADER_SEL: nxt_st.rdata = 32'(st_ff.leader);
                gear_pkg::PRM_RAMP_RATE: nxt_st.rdata = st_ff.rate;
                gear_pkg::PRM_FOLLOW_RATIO: nxt_st.rdata = st_ff.ratio;
                gear_pkg::PRM_LIMIT_ONE: nxt_st.rdata = st_ff.limit_one;
                gear_pkg::PRM_LIMIT_TWO: nxt_st.rdata = st_ff.limit_two;
                gear_pkg::REG_CONTROL: nxt_st.rdata = 32'(st_ff.gantry_sel) << gear_pkg::CTL_GANTRY;
                gear_pkg::REG_STATUS: nxt_st.rdata = {st_ff.eff_ratio[31:4], st_ff.lim2_hit,
                                                      st_ff.lim1_hit, 2'(st_ff.mode)};
                gear_pkg::REG_IRQ_STAT: nxt_st.rdata = 32'(st_ff.ev);
                gear_pkg::REG_IRQ_MASK: nxt_st.rdata = 32'(st_ff.mask);
                gear_pkg::REG_MOTION_STAT: nxt_st.rdata =
                    32'(st_ff.mode != gear_pkg::ST_IDLE) << gear_pkg::FOLLOW_BIT;
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '{mode: gear_pkg::ST_IDLE, ratio: gear_pkg::RST_RATIO,
                       rate: gear_pkg::RST_RATE, limit_one: gear_pkg::RST_LIMIT_ONE,
                       limit_two: gear_pkg::RST_LIMIT_TWO, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign slave_step_o = st_ff.step;
    assign slave_step_valid_o = st_ff.step_valid;
    assign drive_cmd_o = st_ff.cmd;
    assign irq_o = st_ff.irq;

    // ************************************************************
    // checks
    // ************************************************************
    gantry_unity_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_GANTRY |-> st_ff.eff_ratio == gear_pkg::RATIO_UNITY)
        else $error("gantry ratio not unity");
    gantry_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_GANTRY && !(wr_i && addr_i == gear_pkg::REG_CONTROL
        && wdata_i[gear_pkg::CTL_RELEASE]) |=> st_ff.mode == gear_pkg::ST_GANTRY)
        else $error("gantry released without command");
    std_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_STANDARD && wr_i && addr_i == gear_pkg::REG_CONTROL
        && wdata_i[gear_pkg::CTL_STOP] |=> st_ff.mode == gear_pkg::ST_IDLE)
        else $error("standard not released on stop");
    std_inputs_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_STANDARD && !(wr_i && addr_i == gear_pkg::REG_CONTROL)
        |=> !drive_cmd_o.leader_stop)
        else $error("leader stopped in standard mode");
    ramp_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_STANDARD && $past(st_ff.mode) == gear_pkg::ST_STANDARD
        |-> st_ff.eff_ratio - $past(st_ff.eff_ratio) <= st_ff.rate
        || $past(st_ff.eff_ratio) - st_ff.eff_ratio <= st_ff.rate)
        else $error("ratio step beyond rate");
    limit_two_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick_i && st_ff.mode == gear_pkg::ST_GANTRY && pos_err > st_ff.limit_two
        && !st_ff.lim2_hit |=> drive_cmd_o.servo_off && st_ff.lim2_hit)
        else $error("no servo off past limit two");
    limit_one_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick_i && st_ff.mode == gear_pkg::ST_GANTRY && pos_err > st_ff.limit_one
        && !st_ff.lim1_hit |=> drive_cmd_o.slave_stop)
        else $error("no stop past limit one");
    gantry_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick_i && st_ff.mode == gear_pkg::ST_GANTRY
        |=> slave_step_valid_o && slave_step_o == $past(lead_step))
        else $error("gantry step differs from leader");

    // an idle coupler must not move the slave axis
    idle_no_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_IDLE |=> !slave_step_valid_o)
        else $error("step issued while idle");

    // idle coupler sends no drive commands at all
    idle_no_cmd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_IDLE |=> drive_cmd_o == '0)
        else $error("drive command while idle");

    // read data only stands in the cycle after a read strobe
    read_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data without strobe");

    // following flag mirrors the coupled state at the read
    follow_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == gear_pkg::REG_MOTION_STAT
        |=> rdata_o[gear_pkg::FOLLOW_BIT] == ($past(st_ff.mode) != gear_pkg::ST_IDLE))
        else $error("following flag wrong");

    // new alarm-type input in gantry must halt the leader
    gantry_trip_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_GANTRY && in_now && !st_ff.in_act
        |=> drive_cmd_o.leader_stop)
        else $error("leader not stopped on input");

    // stop command in gantry halts both axes
    gantry_halt_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_GANTRY && wr_i && addr_i == gear_pkg::REG_CONTROL
        && !wdata_i[gear_pkg::CTL_RELEASE] && wdata_i[gear_pkg::CTL_STOP]
        |=> drive_cmd_o.leader_stop && drive_cmd_o.slave_stop)
        else $error("gantry stop did not halt both axes");

    // start from idle couples and flags the engage event
    start_engage_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_IDLE && wr_i && addr_i == gear_pkg::REG_CONTROL
        && wdata_i[gear_pkg::CTL_START]
        |=> st_ff.mode != gear_pkg::ST_IDLE && st_ff.ev[gear_pkg::EV_ENGAGED])
        else $error("start did not couple");

    // standard mode never switches a drive off
    std_no_servo_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_STANDARD |=> !drive_cmd_o.servo_off)
        else $error("servo off in standard mode");

    // a sticky event only drops on a status write
    event_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.ev[gear_pkg::EV_ENGAGED] && !(wr_i && addr_i == gear_pkg::REG_IRQ_STAT)
        |=> st_ff.ev[gear_pkg::EV_ENGAGED])
        else $error("event bit lost");

    // limit one fires once per coupling, latch must hold
    limit_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_ff.mode == gear_pkg::ST_GANTRY && st_ff.lim1_hit
        && !(wr_i && addr_i == gear_pkg::REG_CONTROL) |=> st_ff.lim1_hit)
        else $error("limit one latch dropped");

    // a ratio written while coupled is taken at once as the target
    ratio_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_i && addr_i == gear_pkg::PRM_FOLLOW_RATIO |=> st_ff.ratio == $past(wdata_i))
        else $error("ratio write not taken");
endmodule

/* include/gear_pkg.sv */
// package: constants and carrier types for the axis coupler
package gear_pkg;
    // parameter numbers at which the slave axis holds its coupling settings
    localparam logic [7:0] PRM_LEADER_SEL = 8'h60;
    localparam logic [7:0] PRM_RAMP_RATE = 8'h61;
    localparam logic [7:0] PRM_FOLLOW_RATIO = 8'h62;
    localparam logic [7:0] PRM_LIMIT_ONE = 8'h63;
    localparam logic [7:0] PRM_LIMIT_TWO = 8'h64;
    // own registers
    localparam logic [7:0] REG_CONTROL = 8'h70;
    localparam logic [7:0] REG_STATUS = 8'h71;
    localparam logic [7:0] REG_IRQ_STAT = 8'h72;
    localparam logic [7:0] REG_IRQ_MASK = 8'h73;
    localparam logic [7:0] REG_MOTION_STAT = 8'h74;
    // control register bits
    localparam int CTL_START = 0;
    localparam int CTL_RELEASE = 1;
    localparam int CTL_GANTRY = 2;
    localparam int CTL_STOP = 3;
    localparam int CTL_ESTOP = 4;
    localparam int CTL_SERVO_OFF = 5;
    // interrupt event bits
    localparam int EV_ENGAGED = 0;
    localparam int EV_RELEASED = 1;
    localparam int EV_LIMIT_ONE = 2;
    localparam int EV_LIMIT_TWO = 3;
    localparam int EV_INPUT_TRIP = 4;
    localparam int EV_W = 5;
    // slave-following flag inside the motion status word
    localparam int FOLLOW_BIT = 28;
    // axes and ratio format: Q16.16, ratio 1.0 = 32'h0001_0000
    localparam int AXES = 8;
    localparam int AXIS_W = 3;
    localparam int FRAC = 16;
    localparam logic [31:0] RATIO_UNITY = 32'h0001_0000;
    // reset values
    localparam logic [31:0] RST_RATIO = 32'h0001_0000;
    localparam logic [31:0] RST_RATE = 32'h0000_0100;
    localparam logic [31:0] RST_LIMIT_ONE = 32'h0000_1000;
    localparam logic [31:0] RST_LIMIT_TWO = 32'h0000_2000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STANDARD,
        ST_GANTRY
    } couple_e;

    // commands toward the drives, one pulse each
    typedef struct packed {
        logic leader_stop;
        logic slave_stop;
        logic servo_off;
    } drive_cmd_s;

    // slave axis alarm-type inputs
    typedef struct packed {
        logic emergency;
        logic drive_alarm_input;
        logic positive_end_limit;
        logic negative_end_limit;
    } axis_in_s;
endpackage

/* sim/drive_model.sv */
// drive model: slave position, drive enable and alarm-type pins
`timescale 1ns/1ps
module drive_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic signed [31:0] step_i,
    input wire logic step_valid_i,
    input wire gear_pkg::drive_cmd_s cmd_i,
    input wire logic load_i,
    input wire gear_pkg::axis_in_s fault_i,
    output logic signed [31:0] pos_o,
    output gear_pkg::axis_in_s in_o
);
    logic on_ff;
    // position moves only while the drive is powered; load re-homes it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_o <= 32'sh0000_0000;
            on_ff <= 1'b1;
        end else if (load_i) begin
            pos_o <= 32'sh0000_0000;
            on_ff <= 1'b1;
        end else begin
            if (cmd_i.servo_off) on_ff <= 1'b0;
            if (step_valid_i && on_ff) pos_o <= pos_o + step_i;
        end
    end
    // alarm pins are raw and unsynchronised, like real drive outputs
    assign in_o = fault_i;
endmodule

/* sim/testbench.sv */
// self-checking bench for the axis coupler with its drive model
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [7:0] a; logic [31:0] d;} row_s;
    logic sys_clk_i, rst_n_i, wr_i, rd_i, cycle_tick_i, slave_step_valid_o, irq_o, ld;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, val;
    logic signed [31:0] leader_step_i [gear_pkg::AXES];
    logic signed [31:0] leader_pos_i [gear_pkg::AXES];
    logic signed [31:0] slave_pos_i, slave_step_o, got;
    gear_pkg::axis_in_s slave_in_i, fault;
    gear_pkg::drive_cmd_s drive_cmd_o, seen;
    int fails, checks, vcnt;
    longint eff, ratio, exp;
    row_s rows [9] = '{'{gear_pkg::PRM_LEADER_SEL, 32'h0000_0000},
        '{gear_pkg::PRM_RAMP_RATE, 32'h0000_0100}, '{gear_pkg::PRM_FOLLOW_RATIO, 32'h0001_0000},
        '{gear_pkg::PRM_LIMIT_ONE, 32'h0000_1000}, '{gear_pkg::PRM_LIMIT_TWO, 32'h0000_2000},
        '{gear_pkg::REG_STATUS, 32'h0000_0000}, '{gear_pkg::REG_IRQ_STAT, 32'h0000_0000},
        '{gear_pkg::REG_MOTION_STAT, 32'h0000_0000}, '{8'h7f, 32'h0000_0000}};

    gear_coupler u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cycle_tick_i(cycle_tick_i), .leader_step_i(leader_step_i),
        .leader_pos_i(leader_pos_i), .slave_pos_i(slave_pos_i), .slave_in_i(slave_in_i),
        .slave_step_o(slave_step_o), .slave_step_valid_o(slave_step_valid_o),
        .drive_cmd_o(drive_cmd_o), .irq_o(irq_o));
    drive_model u_drive (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .step_i(slave_step_o),
        .step_valid_i(slave_step_valid_o), .cmd_i(drive_cmd_o), .load_i(ld),
        .fault_i(fault), .pos_o(slave_pos_i), .in_o(slave_in_i));

    // 40 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // samples just after each edge so one-cycle pulses are never missed
    task automatic run(input int n);
        seen = '0;
        vcnt = 0;
        repeat (n) begin
            #1;
            seen = seen | drive_cmd_o;
            if (slave_step_valid_o === 1'b1) begin
                vcnt++;
                got = slave_step_o;
            end
            @(posedge sys_clk_i);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        run(6);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge sys_clk_i);
    endtask
    task automatic tick(input logic signed [31:0] s);
        leader_step_i[2] <= s;
        cycle_tick_i <= 1'b1;
        @(posedge sys_clk_i);
        cycle_tick_i <= 1'b0;
        run(3);
    endtask
    task automatic mode_is(input logic [31:0] m);
        rd(gear_pkg::REG_STATUS, val);
        chk(val & 32'h0000_0003, m);
    endtask
    // raise one alarm-type pin and look for a leader stop
    task automatic trip(input int k, input logic e);
        fault <= gear_pkg::axis_in_s'(4'b1000 >> k);
        run(8);
        chk(32'(seen.leader_stop), 32'(e));
        fault <= '0;
        run(6);
    endtask

    initial begin
        {rst_n_i, wr_i, rd_i, cycle_tick_i, ld, addr_i, wdata_i, fault} = '0;
        for (int i = 0; i < gear_pkg::AXES; i++) begin
            leader_step_i[i] = 32'(i * 7);
            leader_pos_i[i] = 32'(i * 3);
        end
        leader_pos_i[2] = 32'sh0000_0000;
        repeat (12) @(posedge sys_clk_i);
        run(1);
        chk(rdata_o, 32'h0000_0000);
        chk(32'({irq_o, slave_step_valid_o, 3'(drive_cmd_o)}), 32'h0000_0000);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int p = 0; p < 2; p++) begin
            foreach (rows[i]) begin
                rd(rows[i].a, val);
                chk(val, rows[i].d);
            end
            $display("test defaults pass %0d done", p);
            if (p == 0) begin
                // ramp up, then live ratio change downward
                wr(gear_pkg::PRM_LEADER_SEL, 32'h0000_0002);
                wr(gear_pkg::PRM_RAMP_RATE, 32'h0000_4000);
                wr(gear_pkg::PRM_FOLLOW_RATIO, 32'h0002_0000);
                wr(gear_pkg::REG_IRQ_MASK, 32'h0000_001f);
                wr(gear_pkg::REG_CONTROL, 32'h0000_0001);
                mode_is(32'h0000_0001);
                rd(gear_pkg::REG_MOTION_STAT, val);
                chk(val & 32'h1000_0000, 32'h1000_0000);
                chk(32'(irq_o), 32'h0000_0001);
                eff = 0;
                ratio = 'h2_0000;
                for (int i = 0; i < 18; i++) begin
                    if (i == 10) begin
                        wr(gear_pkg::PRM_FOLLOW_RATIO, 32'h0000_8000);
                        ratio = 'h8000;
                    end
                    exp = (longint'(1000) * eff) >>> 16;
                    tick(32'sd1000);
                    chk(32'(vcnt), 32'h0000_0001);
                    chk(got, 32'(exp));
                    if (eff < ratio) eff = (eff + 'h4000 > ratio) ? ratio : eff + 'h4000;
                    else eff = (eff - 'h4000 < ratio) ? ratio : eff - 'h4000;
                end
                for (int k = 0; k < 4; k++) trip(k, 1'b0);
                wr(gear_pkg::REG_IRQ_STAT, 32'h0000_001f);
                chk(32'(irq_o), 32'h0000_0000);
                $display("test standard coupling done");
                // each release path drops coupling with no drive pulse
                foreach (rows[b]) begin
                    if (b == 1 || b == 3 || b == 4 || b == 5) begin
                        wr(gear_pkg::REG_CONTROL, 32'h0000_0001);
                        wr(gear_pkg::REG_CONTROL, 32'h0000_0001 << b);
                        chk(32'(seen), 32'h0000_0000);
                        mode_is(32'h0000_0000);
                        tick(32'sd1000);
                        chk(32'(vcnt), 32'h0000_0000);
                    end
                end
                rd(gear_pkg::REG_MOTION_STAT, val);
                chk(val & 32'h1000_0000, 32'h0000_0000);
                $display("test standard release done");
                // masked events must stay off the interrupt line
                wr(gear_pkg::REG_IRQ_MASK, 32'h0000_0000);
                wr(gear_pkg::REG_IRQ_STAT, 32'h0000_001f);
                ld <= 1'b1;
                @(posedge sys_clk_i);
                ld <= 1'b0;
                wr(gear_pkg::REG_CONTROL, 32'h0000_0005);
                chk(32'(irq_o), 32'h0000_0000);
                rd(gear_pkg::REG_IRQ_STAT, val);
                chk(val & 32'h0000_0001, 32'h0000_0001);
                wr(gear_pkg::REG_IRQ_MASK, 32'h0000_0001);
                chk(32'(irq_o), 32'h0000_0001);
                mode_is(32'h0000_0002);
                tick(32'sd1000);
                chk(got, 32'sd1000);
                for (int k = 0; k < 4; k++) trip(k, 1'b1);
                for (int b = 3; b < 6; b++) begin
                    wr(gear_pkg::REG_CONTROL, 32'h0000_0001 << b);
                    chk(32'(seen), {30'h0, 1'b1, 1'b1, 1'(b == 5)});
                    mode_is(32'h0000_0002);
                end
                $display("test gantry commands done");
                ld <= 1'b1;
                @(posedge sys_clk_i);
                ld <= 1'b0;
                leader_pos_i[2] <= 32'sh0000_1000;
                tick(32'sd0);
                chk(32'(seen), 32'h0000_0000);
                leader_pos_i[2] <= -32'sh0000_1001;
                tick(32'sd0);
                chk(32'(seen), 32'h0000_0006);
                leader_pos_i[2] <= 32'sh0000_2001;
                tick(32'sd0);
                chk(32'(seen), 32'h0000_0007);
                mode_is(32'h0000_0002);
                wr(gear_pkg::REG_CONTROL, 32'h0000_0002);
                mode_is(32'h0000_0000);
                $display("test gantry protection done");
                rst_n_i <= 1'b0;
                run(2);
                chk(32'({irq_o, slave_step_valid_o, 3'(drive_cmd_o)}), 32'h0000_0000);
                rst_n_i <= 1'b1;
                @(posedge sys_clk_i);
            end
        end
        give_verdict();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        fails++;
        give_verdict();
    end
endmodule
